// file: rtl/sdr_pkg.sv
// Shared constants, register map and state encoding for the SDR LVDS link block
package sdr_pkg;
	// ****************************************************************
	// Register bus
	// ****************************************************************
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] REG_STAT = 12'h004;
	localparam logic [ADDR_W-1:0] REG_PHASE = 12'h008;
	// Control fields
	localparam int CTRL_W = 3;
	localparam int CTRL_TX_EN = 0;
	localparam int CTRL_RX_EN = 1;
	localparam int CTRL_SOFT_RST = 2;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
	// Status fields
	localparam int STAT_READY = 0;
	localparam int STAT_FILL_LSB = 4;
	localparam int STAT_OVF = 8;
	localparam int STAT_STATE_LSB = 12;
	// Phase register fields
	localparam int PHASE_COMPARE_LSB = 16;

	// ****************************************************************
	// Link geometry
	// ****************************************************************
	localparam int SLICE = 4;
	localparam int LANES = 16;
	localparam int WORD_W = 64;
	localparam int FIFO_DEPTH = 512;
	localparam int FILL_W = 4;

	// ****************************************************************
	// Phase search
	// ****************************************************************
	localparam int PS_W = 9;
	localparam logic [PS_W-1:0] PS_LATE_LIMIT = 9'h060;
	localparam logic [PS_W-1:0] PS_BACKOFF = 9'h040;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SETTLE_NS = 64;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 4;

	typedef enum logic [3:0] {
		PA_OFF,
		PA_SEEK_ZERO,
		PA_IN_ZERO,
		PA_SEEK_ONES,
		PA_NEXT_ZERO,
		PA_NEXT_END,
		PA_RETURN,
		PA_LOCKED
	} align_state_e;
endpackage

// file: rtl/sdr_lvds_quad_serdes.sv
// SDR LVDS quad serdes: lane serializers, forwarded clock, phase search, receive FIFO
//
// What this block does
// [R1] Each transmit lane sends four bits per quarter-rate cycle.
// [R2] Each lane slice is registered once before the serial shifter.
// [R3] A local load pulse moves the settled slice into the shifter.
// [R4] Clock lane alternates one then zero, aligned with the data lanes.
// [R5] Receiver joins the fast receive core with a crossing FIFO; here both FIFO sides run on pclk.
// [R6] Sixteen input lanes give a 64-bit output word read from the FIFO.
// [R7] Ready rises only once phase alignment has finished.
// [R8] FIFO occupancy is reported as a four-bit fill level code.
// [R9] The consumer pops words with an active-high pop enable.
// [R10] Phase setting is stepped by training logic to centre the capture clock.
// [R11] Reference from transmit clock only if frequencies are identical.
// [R12] Alternatively reference and probe both come from the received clock pair.
// [R13] Received words are queued with no word or lane alignment.
// [R14] A quarter-rate clock output must pass a global buffer before use.
// [R15] Consumer starts at fill 1101 with ready and stops below 0010.
// [R16] Equal read and write rates never drain the FIFO once reading.
// [R17] Sixteen per-lane deserializers share one phase alignment unit.
// [R18] Received words are written into the FIFO on the write-side timing.
// [R19] Word goes out as bits 15:0 first through bits 63:48 last.
// [R20] Only the clock lane forms a falling half; data use rising edges.
// [R21] Centre is average minus 64 if zero end exceeds 96, else next window.
// [R22] The receive FIFO holds 512 words of 64 bits.
// [R23] Lane slice bit 0 is sent first and rebuilt first.
// [R24] Reset zeroes transmit lanes, drops ready and clears FIFO pointers.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/10ps
module sdr_lvds_quad_serdes #(
	parameter int FIFO_DEPTH = sdr_pkg::FIFO_DEPTH
) (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [sdr_pkg::ADDR_W-1:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input logic [sdr_pkg::WORD_W-1:0] tx_data,
	output logic tx_word_taken,
	output logic [sdr_pkg::LANES-1:0] tx_pair_pos,
	output logic [sdr_pkg::LANES-1:0] tx_pair_neg,
	output logic tx_clock_pos,
	output logic tx_clock_neg,
	input logic [sdr_pkg::LANES-1:0] rx_lane_pos,
	input logic [sdr_pkg::LANES-1:0] rx_lane_neg,
	input logic rx_clock_pair_pos,
	input logic rx_clock_pair_neg,
	output logic [sdr_pkg::PS_W-1:0] phase_shift_setting,
	input logic fifo_pop_enable,
	output logic [sdr_pkg::WORD_W-1:0] rx_data_out,
	output logic rx_word_valid,
	output logic [sdr_pkg::FILL_W-1:0] fill_level_code,
	output logic ready
);
	import sdr_pkg::*;

	localparam int AW = $clog2(FIFO_DEPTH);

	// ****************************************************************
	// Elaboration check
	// ****************************************************************
	// The fill code takes the top bits of the pointer difference, so depth must be a power of two
	if (FIFO_DEPTH < 32 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("FIFO_DEPTH must be a power of two of at least 32");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic ovf;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [1:0] qcnt;
		logic tx_load;
		logic tx_taken;
		logic [WORD_W-1:0] tx_stage;
		logic [LANES-1:0][SLICE-1:0] tx_shift;
		logic [LANES-1:0] tx_pos;
		logic [LANES-1:0] tx_neg;
		logic clk_pos;
		logic clk_neg;
		logic [LANES-1:0][SLICE-1:0] rx_shift;
		logic [1:0] samp;
		align_state_e pst;
		logic [SETTLE_W-1:0] settle;
		logic [PS_W-1:0] ps_count;
		logic [PS_W-1:0] zero_end;
		logic [PS_W-1:0] ones_start;
		logic [PS_W-1:0] ps_compare;
		logic ready;
		logic [AW:0] wptr;
		logic [AW:0] rptr;
		logic [WORD_W-1:0] rdata;
		logic rvalid;
		logic [FILL_W-1:0] fill;
	} state_s;

	state_s s_q;
	state_s s_d;
	logic [WORD_W-1:0] mem [FIFO_DEPTH];
	logic [WORD_W-1:0] rx_word;
	logic fifo_we;
	logic tx_en;
	logic rx_en;
	logic srst;
	logic [AW:0] occ;
	logic [PS_W:0] sum;

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		logic apb_wr;
		logic step;
		logic searching;
		logic sync_bit;
		apb_wr = 1'b0;
		step = 1'b0;
		searching = 1'b0;
		sync_bit = 1'b0;
		s_d = s_q;
		tx_en = s_q.ctrl[CTRL_TX_EN];
		rx_en = s_q.ctrl[CTRL_RX_EN];
		srst = s_q.ctrl[CTRL_SOFT_RST];
		occ = s_q.wptr - s_q.rptr;
		fifo_we = 1'b0;
		rx_word = '0;
		sum = '0;

		// APB slave: one wait state, then pready for a single cycle
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		if (psel && penable && !s_q.pready) begin
			s_d.pready = 1'b1;
			case (paddr)
				REG_CTRL: s_d.prdata = {{(32-CTRL_W){1'b0}}, s_q.ctrl};
				REG_STAT: begin
					s_d.prdata = '0;
					s_d.prdata[STAT_READY] = s_q.ready;
					s_d.prdata[STAT_FILL_LSB +: FILL_W] = s_q.fill;
					s_d.prdata[STAT_OVF] = s_q.ovf;
					s_d.prdata[STAT_STATE_LSB +: 4] = s_q.pst;
				end
				REG_PHASE: begin
					s_d.prdata = '0;
					s_d.prdata[PS_W-1:0] = s_q.ps_count;
					s_d.prdata[PHASE_COMPARE_LSB +: PS_W] = s_q.ps_compare;
				end
				default: begin
					s_d.prdata = '0;
					s_d.pslverr = 1'b1;
				end
			endcase
		end
		// Writes land on the edge that completes the access
		apb_wr = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
		if (apb_wr && paddr == REG_CTRL) begin
			s_d.ctrl = pwdata[CTRL_W-1:0];
		end

		// Quarter-rate phase counter, free running
		s_d.qcnt = s_q.qcnt + 2'h1;

		// Stage the word once per quarter cycle; settles a full two cycles before load
		s_d.tx_taken = 1'b0;
		if (s_q.qcnt == 2'h0 && tx_en) begin
			s_d.tx_stage = tx_data; // R2
			s_d.tx_taken = 1'b1;
		end
		s_d.tx_load = (s_q.qcnt == 2'h2); // R3

		// Clock lane: first half one, second half zero
		s_d.clk_pos = tx_en ? !s_q.clk_pos : 1'b0; // R4
		s_d.clk_neg = tx_en ? s_q.clk_pos : 1'b0; // R20

		// Deserializer word: lane i bit k maps to word bit 16*k+i
		for (int i = 0; i < LANES; i++) begin
			for (int k = 0; k < SLICE; k++) begin
				rx_word[LANES*k + i] = s_q.rx_shift[i][k]; // R13
			end
		end

		// Sampled sync pair, previous and current sample
		sync_bit = rx_clock_pair_pos & ~rx_clock_pair_neg;
		s_d.samp = {s_q.samp[0], sync_bit};

		// Phase search walks ps_count, one step per settle interval
		if (s_q.settle != '0) begin
			s_d.settle = s_q.settle - 1'b1;
		end
		step = (s_q.settle == '0);
		searching = (s_q.pst inside {PA_SEEK_ZERO, PA_IN_ZERO, PA_SEEK_ONES,
			PA_NEXT_ZERO, PA_NEXT_END});
		sum = {1'b0, s_q.zero_end} + {1'b0, s_q.ones_start};
		case (s_q.pst)
			PA_OFF: begin
				s_d.ps_count = '0;
				if (rx_en) begin
					s_d.pst = PA_SEEK_ZERO;
					s_d.settle = SETTLE_W'(SETTLE_CYC);
				end
			end
			PA_SEEK_ZERO: if (step && s_q.samp == 2'b00) s_d.pst = PA_IN_ZERO;
			PA_IN_ZERO: begin
				if (step && s_q.samp != 2'b00) begin
					s_d.zero_end = s_q.ps_count;
					s_d.pst = PA_SEEK_ONES;
				end
			end
			PA_SEEK_ONES: begin
				if (step && s_q.samp == 2'b11) begin
					s_d.ones_start = s_q.ps_count;
					sum = {1'b0, s_q.zero_end} + {1'b0, s_q.ps_count};
					if (s_q.zero_end > PS_LATE_LIMIT) begin
						s_d.ps_compare = sum[PS_W:1] - PS_BACKOFF; // R21
						s_d.pst = PA_RETURN;
					end else begin
						s_d.pst = PA_NEXT_ZERO; // R21
					end
				end
			end
			PA_NEXT_ZERO: if (step && s_q.samp == 2'b00) s_d.pst = PA_NEXT_END;
			PA_NEXT_END: begin
				if (step && s_q.samp != 2'b00) begin
					s_d.zero_end = s_q.ps_count;
					sum = {1'b0, s_q.ones_start} + {1'b0, s_q.ps_count};
					s_d.ps_compare = sum[PS_W:1]; // R21
					s_d.pst = PA_RETURN;
				end
			end
			PA_RETURN: begin
				if (s_q.ps_count == s_q.ps_compare) begin
					s_d.pst = PA_LOCKED;
					s_d.ready = 1'b1; // R7
				end else if (step) begin
					s_d.ps_count = s_q.ps_count - 1'b1;
					s_d.settle = SETTLE_W'(SETTLE_CYC);
				end
			end
			PA_LOCKED: s_d.ready = 1'b1;
			default: s_d.pst = PA_OFF;
		endcase
		if (searching && step) begin
			s_d.ps_count = s_q.ps_count + 1'b1; // R10
			s_d.settle = SETTLE_W'(SETTLE_CYC);
		end
		if (!rx_en) begin
			s_d.pst = PA_OFF;
			s_d.ready = 1'b0;
		end

		// Write a word every quarter cycle once aligned; overflow drops it
		if (s_q.qcnt == 2'h0 && s_q.ready && rx_en) begin
			if (occ[AW]) begin
				s_d.ovf = 1'b1;
			end else begin
				fifo_we = 1'b1; // R18
				s_d.wptr = s_q.wptr + 1'b1;
			end
		end
		// Overflow flag: write one to clear, a new overflow wins
		if (apb_wr && paddr == REG_STAT && pwdata[STAT_OVF] && !(fifo_we == 1'b0
			&& s_q.qcnt == 2'h0 && s_q.ready && rx_en)) begin
			s_d.ovf = 1'b0;
		end

		// Read side: pop is ignored while empty
		s_d.rvalid = 1'b0;
		if (fifo_pop_enable && occ != '0) begin
			s_d.rdata = mem[s_q.rptr[AW-1:0]]; // R6
			s_d.rptr = s_q.rptr + 1'b1;
			s_d.rvalid = 1'b1;
		end
		s_d.fill = occ[AW] ? {FILL_W{1'b1}} : occ[AW-1 -: FILL_W]; // R8

		// Soft reset holds the datapath quiet and empties the FIFO
		if (srst) begin
			s_d.tx_stage = '0; // R24
			s_d.tx_taken = 1'b0;
			s_d.clk_pos = 1'b0;
			s_d.clk_neg = 1'b0;
			s_d.pst = PA_OFF;
			s_d.ready = 1'b0;
			s_d.wptr = '0;
			s_d.rptr = '0;
			s_d.rvalid = 1'b0;
			s_d.fill = '0;
			fifo_we = 1'b0;
		end
	end

	// ****************************************************************
	// Per-lane serializer and deserializer
	// ****************************************************************
	// Each lane shifts bit 0 out first; receive shifts in from the top so bit 0 ends low
	logic [LANES-1:0][SLICE-1:0] s_d_lane_shift;
	logic [LANES-1:0] s_d_lane_pos;
	logic [LANES-1:0][SLICE-1:0] s_d_lane_rx;
	for (genvar i = 0; i < LANES; i++) begin : g_lane
		logic [SLICE-1:0] slice;
		logic [SLICE-1:0] shift_n;
		assign slice = {s_q.tx_stage[3*LANES+i], s_q.tx_stage[2*LANES+i],
			s_q.tx_stage[LANES+i], s_q.tx_stage[i]}; // R19
		assign shift_n = s_q.tx_load ? slice : {1'b0, s_q.tx_shift[i][SLICE-1:1]}; // R1
		// Each lane drives only its own element of the shared next-value arrays
		assign s_d_lane_shift[i] = srst ? '0 : shift_n;
		assign s_d_lane_pos[i] = (tx_en && !srst) ? shift_n[0] : 1'b0; // R23
		assign s_d_lane_rx[i] = {rx_lane_pos[i] & ~rx_lane_neg[i],
			s_q.rx_shift[i][SLICE-1:1]}; // R17
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.ctrl <= CTRL_RESET;
			s_q.pst <= PA_OFF;
		end else begin
			s_q <= s_d;
			s_q.tx_shift <= s_d_lane_shift;
			s_q.tx_pos <= s_d_lane_pos;
			s_q.tx_neg <= (tx_en && !srst) ? ~s_d_lane_pos : '0;
			s_q.rx_shift <= s_d_lane_rx;
		end
	end

	// FIFO storage, no reset needed on the array itself
	always_ff @(posedge pclk) begin
		if (fifo_we) begin
			mem[s_q.wptr[AW-1:0]] <= rx_word; // R5
		end
	end

	// Outputs straight from flops
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign tx_word_taken = s_q.tx_taken;
	assign tx_pair_pos = s_q.tx_pos;
	assign tx_pair_neg = s_q.tx_neg;
	assign tx_clock_pos = s_q.clk_pos;
	assign tx_clock_neg = s_q.clk_neg;
	assign phase_shift_setting = s_q.ps_count;
	assign rx_data_out = s_q.rdata;
	assign rx_word_valid = s_q.rvalid;
	assign fill_level_code = s_q.fill;
	assign ready = s_q.ready;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	// Step strobe seen by the phase search, for the centre check
	logic step_probe;
	assign step_probe = (s_q.settle == '0);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence load_gap;
		!s_q.tx_load [*3] ##1 s_q.tx_load;
	endsequence

	a_load_spacing: assert property (s_q.tx_load |=> load_gap) // R3
		else $error("load pulse not every fourth cycle");

	a_serial_order: assert property (s_q.tx_load && tx_en && !srst && $stable(s_q.ctrl)
		|=> tx_pair_pos[0] == $past(s_q.tx_stage[0]) ##1
		(tx_pair_pos[0] == $past(s_q.tx_stage[LANES], 2) || $past(srst) || !$past(tx_en))) // R23
		else $error("lane 0 did not send slice bit 0 then bit 1");

	a_clock_toggle: assert property (tx_en && !srst && $stable(s_q.ctrl)
		|=> tx_clock_pos != $past(tx_clock_pos) && tx_clock_neg == $past(tx_clock_pos)) // R4
		else $error("forwarded clock lane did not alternate");

	a_reset_quiet: assert property (srst |=> tx_pair_pos == '0 && !ready
		&& fill_level_code == '0 && !tx_clock_pos) // R24
		else $error("soft reset did not quiet outputs");

	a_ready_locked: assert property (ready |-> s_q.pst == PA_LOCKED) // R7
		else $error("ready without completed alignment");

	a_centre_late: assert property (s_q.pst == PA_SEEK_ONES && step_probe
		&& s_q.samp == 2'b11 && s_q.zero_end > PS_LATE_LIMIT && rx_en && !srst
		|=> s_q.ps_compare == PS_W'((({1'b0, $past(s_q.zero_end)}
		+ {1'b0, $past(s_q.ps_count)}) >> 1) - PS_BACKOFF)) // R21
		else $error("late window centre wrong");

	a_no_overrun: assert property (occ <= FIFO_DEPTH) // R22
		else $error("FIFO holds more than its depth");

	a_pop_valid: assert property (rx_word_valid |-> $past(fifo_pop_enable)
		&& $past(occ) != '0) // R6
		else $error("word valid without a pop from a non-empty FIFO");
endmodule

// file: tb/sdr_far_end.sv
// Far-side chip model: steady lane pattern and a probe clock that follows the phase setting
`timescale 1ns/10ps
module sdr_far_end (
	input logic pclk,
	input logic presetn,
	input logic [8:0] phase_shift_setting,
	input logic [15:0] lane_pattern,
	output logic [15:0] rx_lane_pos = 16'h0000,
	output logic [15:0] rx_lane_neg = 16'hffff,
	output logic rx_clock_pair_pos = 1'b0,
	output logic rx_clock_pair_neg = 1'b1
);
	// ****************************************************************
	// Probe and lane drive
	// ****************************************************************
	logic flip_q = 1'b0;
	logic probe;
	// Zeros below 128, ones from 144; between them the level flips each cycle,
	// so no steady pair is ever seen at the window edge
	assign probe = (phase_shift_setting[7:0] >= 8'h90) | ((phase_shift_setting[7:0] >= 8'h80) & flip_q);
	// Lines change only just after a rising edge
	always @(posedge pclk) begin
		if (!presetn) begin
			flip_q <= 1'b0;
			rx_clock_pair_pos <= 1'b0;
			rx_clock_pair_neg <= 1'b1;
		end else begin
			flip_q <= ~flip_q;
			rx_clock_pair_pos <= probe;
			rx_clock_pair_neg <= ~probe;
		end
		rx_lane_pos <= lane_pattern;
		rx_lane_neg <= ~lane_pattern;
	end
endmodule

// file: tb/sdr_lvds_quad_serdes_bench.sv
// Self-checking bench for the SDR LVDS quad serdes block
`timescale 1ns/10ps
`define CHK(n,e,g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
`define WAITC(c,n) begin int w; w = 0; while (!(c) && w < n) begin @(posedge pclk); \
	w++; end if (!(c)) timeout(); end
module sdr_lvds_quad_serdes_bench;
	import sdr_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h7337;
	logic pready, pslverr, er, tx_word_taken, tx_clock_pos, tx_clock_neg;
	logic [63:0] tx_data = 64'h0, rx_data_out, nw, ex;
	logic [15:0] tx_pair_pos, tx_pair_neg, rx_lane_pos, rx_lane_neg, lane_pattern = 16'h0;
	logic rx_clock_pair_pos, rx_clock_pair_neg, rx_word_valid, ready;
	logic fifo_pop_enable = 1'b0, ck_on = 1'b0, ck_prev = 1'b0, run_rx = 1'b0;
	logic [8:0] phase_shift_setting;
	logic [3:0] fill_level_code;
	logic [63:0] txq[$], rxq[$], tw[0:6];
	logic [6:0] tv = 7'h00;
	int fail_count = 0, total_checks = 0;

	sdr_lvds_quad_serdes dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
		.tx_word_taken(tx_word_taken), .tx_pair_pos(tx_pair_pos), .tx_pair_neg(tx_pair_neg),
		.tx_clock_pos(tx_clock_pos), .tx_clock_neg(tx_clock_neg), .rx_lane_pos(rx_lane_pos),
		.rx_lane_neg(rx_lane_neg), .rx_clock_pair_pos(rx_clock_pair_pos),
		.rx_clock_pair_neg(rx_clock_pair_neg), .phase_shift_setting(phase_shift_setting),
		.fifo_pop_enable(fifo_pop_enable), .rx_data_out(rx_data_out),
		.rx_word_valid(rx_word_valid), .fill_level_code(fill_level_code), .ready(ready));
	sdr_far_end far_u (.pclk(pclk), .presetn(presetn), .phase_shift_setting(phase_shift_setting),
		.lane_pattern(lane_pattern), .rx_lane_pos(rx_lane_pos), .rx_lane_neg(rx_lane_neg),
		.rx_clock_pair_pos(rx_clock_pair_pos), .rx_clock_pair_neg(rx_clock_pair_neg));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// 125 MHz clock
	always #4 pclk = ~pclk;
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task results();
		if (fail_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task timeout();
		fail_count++;
		$display("[ERR] wait exp 1 got 0");
		results();
	endtask
	// One APB transfer; request held until pready is sampled high
	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		`WAITC(pready === 1'b1 && penable === 1'b1, 50)
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Word driver: a new random word only once the previous one was taken
	initial begin
		rd = xs();
		lane_pattern = rd[15:0];
		tx_data = {xs(), xs()};
		txq.push_back(tx_data);
		repeat (5) begin
			@(posedge pclk);
			`WAITC(tx_word_taken === 1'b1, 3000)
			nw = {xs(), xs()};
			tx_data <= nw;
			txq.push_back(nw);
		end
	end

	// Reader with high and low water marks; each pop notes the word it expects
	always @(posedge pclk) begin
		if (fifo_pop_enable === 1'b1) rxq.push_back({4{lane_pattern}});
		if (!presetn || fill_level_code < 4'h2) fifo_pop_enable <= 1'b0;
		else if (run_rx && ready === 1'b1 && fill_level_code == 4'hd) fifo_pop_enable <= 1'b1;
	end

	// Output watcher: lane groups appear three edges after the take pulse
	always @(posedge pclk) begin
		for (int s = 6; s > 0; s--) begin
			tw[s] = tw[s-1];
			tv[s] = tv[s-1];
		end
		tv[0] = tx_word_taken === 1'b1 && txq.size() > 0;
		if (tv[0]) tw[0] = txq.pop_front();
		for (int s = 3; s < 7; s++) begin
			if (tv[s]) begin
				`CHK("tx_pair_pos", tw[s][16*(s-3)+:16], tx_pair_pos)
				`CHK("tx_pair_neg", ~tw[s][16*(s-3)+:16], tx_pair_neg)
			end
		end
		if (ck_on) `CHK("tx_clock_pos", ~ck_prev, tx_clock_pos)
		if (ck_on) `CHK("tx_clock_neg", ck_prev, tx_clock_neg)
		ck_prev = tx_clock_pos;
		if (rx_word_valid === 1'b1) begin
			ex = rxq.size() > 0 ? rxq.pop_front() : ~rx_data_out;
			`CHK("rx_data_out", ex, rx_data_out)
		end
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (8) @(posedge pclk);
		`CHK("reset_out", 38'h0, {tx_pair_pos, tx_pair_neg, tx_clock_pos, ready, fill_level_code})
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, REG_CTRL, 32'h1);
		repeat (4) @(posedge pclk);
		ck_on = 1'b1;
		apb(1'b0, 12'h00c, 32'h0);
		`CHK("unmapped_err", 1'b1, er)
		`CHK("unmapped_data", 32'h0, rd)
		apb(1'b1, REG_CTRL, 32'h3);
		apb(1'b0, REG_CTRL, 32'h0);
		`CHK("ctrl", 32'h3, rd)
		`WAITC(ready === 1'b1, 6000)
		`CHK("phase", 9'h048, phase_shift_setting)
		apb(1'b0, REG_PHASE, 32'h0);
		`CHK("centre", 9'h048, rd[24:16])
		run_rx = 1'b1;
		`WAITC(fifo_pop_enable === 1'b1, 4000)
		`WAITC(fifo_pop_enable === 1'b0, 4000)
		run_rx = 1'b0;
		repeat (4) @(posedge pclk);
		`CHK("rx_backlog", 0, rxq.size())
		// Fill past capacity: 512 words then one more sets overflow
		`WAITC(fill_level_code === 4'hf, 4000)
		repeat (200) @(posedge pclk);
		apb(1'b0, REG_STAT, 32'h0);
		`CHK("stat", 6'h3f, {rd[8], rd[7:4], rd[0]})
		ck_on = 1'b0;
		apb(1'b1, REG_CTRL, 32'h7);
		repeat (2) @(posedge pclk);
		`CHK("soft_reset", 21'h0, {tx_pair_pos, fill_level_code, ready})
		results();
	end
endmodule
